// File: logic/wavegen.sv
// Multi-instance 16-bit waveform generator with offset synchronisation.
// Assumes an AHB-Lite master with word transfers; ext_tick inputs are
// synchronous single-cycle enables from other clock sources.
// Operation
// - Own 16-bit timer, selectable clock, compared to counts
// - Enable bit plus shared multi-enable register
// - Output-state read synchronised to quarter-rate clock
// - Polarity bit inverts output, even while disabled
// - Standard: on at phase, off at duty
// - Standard period is (period+1) times prescale
// - Set-on-match: phase sets, held until cleared
// - Software output write applies at next tick
// - Toggle mode flips output at phase match
// - Standard, toggle and center ignore output-state writes
// - Center mode counts up then down
// - Center on at period-duty, off one above
// - Center period is twice (period+1) times prescale
// - Independent run ignores peers, period resets timer
// - Sync start waits for master offset hit
// - One-shot runs one period per master hit, in center mode only up to the top count
// - One-shot ignores master hits while running
// - Restart mode reloads timer to one on hits
// - Offset alignment kept when switching to independent
// - Center offset hit direction chosen by bit
// - Buffered counts load at period when armed
// - Four flags set on match rising edges
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module wavegen #(
  parameter int N_INST = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] ext_tick,
  output logic [N_INST-1:0] wave_out,
  output logic [N_INST-1:0] offset_hit_out
);

  typedef struct packed {
    wavegen_pkg::inst_s [N_INST-1:0] ch;
    logic [1:0] div;
    logic wr_pend;
    logic rd_pend;
    logic [9:2] addr;
    logic [31:0] rdata;
    logic rdy;
  } state_s;

  state_s q;
  state_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [31:0] rd_word(input state_s s, input logic [9:2] a);
    logic [31:0] r;
    logic [5:0] o;
    int k;
    r = wavegen_pkg::RDATA_UNMAPPED;
    o = {a[5:2], 2'b00};
    k = int'(a[8:6]);
    if ({a, 2'b00} == wavegen_pkg::SHARED_EN_ADDR) begin
      for (int i = 0; i < N_INST; i++) begin
        r[i] = s.ch[i].en;
      end
    end else if (!a[9] && k < N_INST) begin
      unique case (o)
        wavegen_pkg::OFS_CTRL: begin
          r[wavegen_pkg::EN_BIT] = s.ch[k].en;
          r[wavegen_pkg::OUT_BIT] = s.ch[k].out_sync;
          r[wavegen_pkg::POL_BIT] = s.ch[k].output_invert_bit;
          r[wavegen_pkg::MODE_LSB +: 2] = s.ch[k].mode;
        end
        wavegen_pkg::OFS_CLKSEL: begin
          r[wavegen_pkg::CS_LSB +: 2] = s.ch[k].cs;
          r[wavegen_pkg::PS_LSB +: 3] = s.ch[k].ps;
        end
        wavegen_pkg::OFS_PHASE: r[15:0] = s.ch[k].ph_b;
        wavegen_pkg::OFS_DUTY: r[15:0] = s.ch[k].dc_b;
        wavegen_pkg::OFS_PERIOD: r[15:0] = s.ch[k].pr_b;
        wavegen_pkg::OFS_OFFSET: r[15:0] = s.ch[k].of_b;
        wavegen_pkg::OFS_OFSCTRL: begin
          r[wavegen_pkg::MSEL_LSB +: 3] = s.ch[k].msel;
          r[wavegen_pkg::OFO_BIT] = s.ch[k].ofo_b;
          r[wavegen_pkg::OFM_LSB +: 2] = s.ch[k].sync_mode_field;
          r[wavegen_pkg::LDA_BIT] = s.ch[k].load_arm_bit;
        end
        wavegen_pkg::OFS_TIMER: r[15:0] = s.ch[k].tmr;
        wavegen_pkg::OFS_FLAGS: r[3:0] = s.ch[k].flags;
        default: r = wavegen_pkg::RDATA_UNMAPPED;
      endcase
    end
    return r;
  endfunction : rd_word

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    wavegen_pkg::inst_s c;
    logic [3:0] fset [N_INST];
    logic [3:0] lvl;
    logic [7:0] psmask;
    logic [15:0] on_val;
    logic src;
    logic tick;
    logic pm;
    logic dm;
    logic prm;
    logic pev;
    logic ctr;
    logic mhit;
    logic sync;
    logic go;
    logic was_run;
    logic [5:0] wo;
    int wk;
    c = '0;
    fset = '{default: 4'h0};
    lvl = '0;
    psmask = '0;
    on_val = '0;
    src = 1'b0;
    tick = 1'b0;
    pm = 1'b0;
    dm = 1'b0;
    prm = 1'b0;
    pev = 1'b0;
    ctr = 1'b0;
    mhit = 1'b0;
    sync = 1'b0;
    go = 1'b0;
    was_run = 1'b0;
    wo = '0;
    wk = 0;
    d = q;
    d.div = q.div + 2'h1;

    for (int i = 0; i < N_INST; i++) begin
      c = q.ch[i];
      // Counter clock: selected source divided by 2^ps
      src = (c.cs == 2'h0) ? 1'b1 : ext_tick[c.cs - 2'h1];
      psmask = 8'((9'h001 << c.ps) - 9'h001);
      tick = c.en && src && (c.pscnt == psmask);
      if (!c.en) begin
        c.pscnt = 8'h00;
      end else if (src) begin
        c.pscnt = tick ? 8'h00 : c.pscnt + 8'h01;
      end
      ctr = (c.mode == wavegen_pkg::MODE_CENTER);
      // Compare against active copies only
      pm = (c.tmr == c.ph_a);
      dm = (c.tmr == c.dc_a);
      prm = (c.tmr == c.pr_a);
      pev = prm && (!ctr || !c.dir);
      // Master hit is latched so a slower slave clock cannot miss it
      mhit = (int'(c.msel) < N_INST) ? q.ch[c.msel].hit : 1'b0;
      sync = c.pend || mhit;
      c.pend = c.en && sync && !tick;
      lvl = {(c.tmr == c.of_a), pm, dm, prm} & {4{c.en}};
      fset[i] = lvl & ~c.mprev;
      c.mprev = lvl;
      c.hit = 1'b0;
      if (!c.en) begin
        c.run = 1'b0;
        c.dir = 1'b0;
        c.oact = 1'b0;
        c.sw_pend = 1'b0;
      end else if (tick) begin
        was_run = c.run;
        go = (c.sync_mode_field == wavegen_pkg::OFM_INDEP) || c.run || sync;
        if (sync) begin
          c.run = 1'b1;
        end
        if (go) begin
          // Offset hit in center mode only in the chosen direction
          c.hit = (c.tmr == c.of_a) && (!ctr || (c.dir == c.ofo_a));
          unique case (c.mode)
            wavegen_pkg::MODE_STD: begin
              if (pm) c.oact = 1'b1;
              if (dm) c.oact = 1'b0;
            end
            wavegen_pkg::MODE_SET: begin
              if (pm && c.tmr <= c.pr_a) c.oact = 1'b1;
            end
            wavegen_pkg::MODE_TOGGLE: begin
              if (pm) c.oact = !c.oact;
            end
            wavegen_pkg::MODE_CENTER: begin
              on_val = c.pr_a - c.dc_a;
              if (!c.dir && c.tmr == on_val) c.oact = 1'b1;
              if (c.dir && c.tmr == on_val + 16'h0001) c.oact = 1'b0;
            end
          endcase
          if (ctr) begin
            // Dwell one tick at each end: 2*(pr+1) ticks per cycle
            if (!c.dir) begin
              if (c.tmr >= c.pr_a) c.dir = 1'b1;
              else c.tmr = c.tmr + 16'h0001;
            end else begin
              if (c.tmr == wavegen_pkg::COUNT_RST) c.dir = 1'b0;
              else c.tmr = c.tmr - 16'h0001;
            end
          end else if (prm) begin
            c.tmr = wavegen_pkg::COUNT_RST;
          end else begin
            c.tmr = c.tmr + 16'h0001;
          end
          if (c.sync_mode_field == wavegen_pkg::OFM_RESTART && was_run && sync) begin
            c.tmr = 16'h0001;
          end
          if (c.sync_mode_field == wavegen_pkg::OFM_ONE_SHOT && pev) begin
            c.tmr = wavegen_pkg::COUNT_RST;
            c.run = 1'b0;
          end
          if (pev && c.load_arm_bit) begin
            c.ph_a = c.ph_b;
            c.dc_a = c.dc_b;
            c.pr_a = c.pr_b;
            c.of_a = c.of_b;
            c.ofo_a = c.ofo_b;
            c.load_arm_bit = 1'b0;
          end
        end
        if (c.sw_pend) begin
          c.oact = c.sw_val;
          c.sw_pend = 1'b0;
        end
      end
      c.wave = c.oact ^ c.output_invert_bit;
      if (q.div == wavegen_pkg::INSN_DIV_LAST) begin
        c.out_sync = q.ch[i].wave;
      end
      d.ch[i] = c;
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus data phase

    if (q.wr_pend) begin
      wo = {q.addr[5:2], 2'b00};
      wk = int'(q.addr[8:6]);
      if ({q.addr, 2'b00} == wavegen_pkg::SHARED_EN_ADDR) begin
        for (int i = 0; i < N_INST; i++) begin
          d.ch[i].en = hwdata[i];
        end
      end else if (!q.addr[9] && wk < N_INST) begin
        unique case (wo)
          wavegen_pkg::OFS_CTRL: begin
            d.ch[wk].en = hwdata[wavegen_pkg::EN_BIT];
            d.ch[wk].output_invert_bit = hwdata[wavegen_pkg::POL_BIT];
            d.ch[wk].mode = wavegen_pkg::mode_e'(hwdata[wavegen_pkg::MODE_LSB +: 2]);
            // Other modes drop output writes
            if (d.ch[wk].mode == wavegen_pkg::MODE_SET) begin
              d.ch[wk].sw_pend = 1'b1;
              d.ch[wk].sw_val = hwdata[wavegen_pkg::OUT_BIT];
            end
          end
          wavegen_pkg::OFS_CLKSEL: begin
            d.ch[wk].cs = hwdata[wavegen_pkg::CS_LSB +: 2];
            d.ch[wk].ps = hwdata[wavegen_pkg::PS_LSB +: 3];
          end
          wavegen_pkg::OFS_PHASE: d.ch[wk].ph_b = hwdata[15:0];
          wavegen_pkg::OFS_DUTY: d.ch[wk].dc_b = hwdata[15:0];
          wavegen_pkg::OFS_PERIOD: d.ch[wk].pr_b = hwdata[15:0];
          wavegen_pkg::OFS_OFFSET: d.ch[wk].of_b = hwdata[15:0];
          wavegen_pkg::OFS_OFSCTRL: begin
            d.ch[wk].msel = hwdata[wavegen_pkg::MSEL_LSB +: 3];
            d.ch[wk].ofo_b = hwdata[wavegen_pkg::OFO_BIT];
            // No timer reset here, so alignment survives a mode change
            d.ch[wk].sync_mode_field = wavegen_pkg::ofm_e'(hwdata[wavegen_pkg::OFM_LSB +: 2]);
            d.ch[wk].load_arm_bit = hwdata[wavegen_pkg::LDA_BIT];
          end
          wavegen_pkg::OFS_TIMER: d.ch[wk].tmr = hwdata[15:0];
          wavegen_pkg::OFS_FLAGS: d.ch[wk].flags = d.ch[wk].flags & ~hwdata[3:0];
          default: d.ch[wk].flags = d.ch[wk].flags;
        endcase
      end
    end
    // Hardware set wins over a same-cycle clear
    for (int i = 0; i < N_INST; i++) begin
      d.ch[i].flags = d.ch[i].flags | fset[i];
    end

    // Reads take one wait state so a preceding write is always visible
    d.wr_pend = 1'b0;
    if (q.rd_pend) begin
      d.rdata = rd_word(q, q.addr);
      d.rd_pend = 1'b0;
      d.rdy = 1'b1;
    end
    if (hsel && hready && htrans[1]) begin
      d.addr = haddr[9:2];
      d.wr_pend = hwrite;
      d.rd_pend = !hwrite;
      d.rdy = hwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register and outputs

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp = 1'b0;

  generate
    for (genvar g = 0; g < N_INST; g++) begin : g_out
      assign wave_out[g] = q.ch[g].wave;
      assign offset_hit_out[g] = q.ch[g].hit;
    end
  endgenerate

endmodule : wavegen
`default_nettype wire

// File: logic/wavegen_pkg.sv
// Package for the offset-synchronised waveform generator: register map,
// field positions, reset values, modes and the per-instance state carrier.
// Assumes a 32-bit AHB-Lite register bus and up to eight instances.
package wavegen_pkg;

  // Register byte offsets inside one instance window
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CLKSEL = 6'h04;
  localparam logic [5:0] OFS_PHASE = 6'h08;
  localparam logic [5:0] OFS_DUTY = 6'h0c;
  localparam logic [5:0] OFS_PERIOD = 6'h10;
  localparam logic [5:0] OFS_OFFSET = 6'h14;
  localparam logic [5:0] OFS_OFSCTRL = 6'h18;
  localparam logic [5:0] OFS_TIMER = 6'h1c;
  localparam logic [5:0] OFS_FLAGS = 6'h20;
  // Instance windows are 64 bytes apart; the shared enable sits above them
  localparam int INST_SHIFT = 6;
  localparam logic [9:0] SHARED_EN_ADDR = 10'h200;
  localparam int MAX_INST = 8;

  // waveform_control_reg fields
  localparam int EN_BIT = 7;
  localparam int OUT_BIT = 5;
  localparam int POL_BIT = 4;
  localparam int MODE_LSB = 2;
  // counter_clock_select_reg fields
  localparam int CS_LSB = 0;
  localparam int PS_LSB = 2;
  // offset_control_reg fields
  localparam int MSEL_LSB = 0;
  localparam int OFO_BIT = 3;
  localparam int OFM_LSB = 4;
  localparam int LDA_BIT = 7;
  // Flag bit positions
  localparam int FLAG_PR = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_PH = 2;
  localparam int FLAG_OF = 3;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
  // Instruction clock is the bus clock divided by four
  localparam logic [1:0] INSN_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_SET = 2'b01,
    MODE_TOGGLE = 2'b10,
    MODE_CENTER = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    OFM_INDEP = 2'b00,
    OFM_SYNC_START = 2'b01,
    OFM_ONE_SHOT = 2'b10,
    OFM_RESTART = 2'b11
  } ofm_e;

  typedef struct packed {
    logic en;
    logic output_invert_bit;
    mode_e mode;
    logic [1:0] cs;
    logic [2:0] ps;
    ofm_e sync_mode_field;
    logic ofo_b;
    logic ofo_a;
    logic load_arm_bit;
    logic [2:0] msel;
    logic [15:0] ph_b;
    logic [15:0] dc_b;
    logic [15:0] pr_b;
    logic [15:0] of_b;
    logic [15:0] ph_a;
    logic [15:0] dc_a;
    logic [15:0] pr_a;
    logic [15:0] of_a;
    logic [15:0] tmr;
    logic [7:0] pscnt;
    logic run;
    logic dir;
    logic pend;
    logic oact;
    logic sw_pend;
    logic sw_val;
    logic [3:0] mprev;
    logic [3:0] flags;
    logic out_sync;
    logic wave;
    logic hit;
  } inst_s;

endpackage : wavegen_pkg

// File: test/wavegen_assertions.sv
// Checker for wavegen: bus timing, register readback, idle output.
// Sees only the top ports; hready is the slave's own hreadyout.
`timescale 1ns/100ps
`default_nettype none
module wavegen_assertions #(
  parameter int N_INST = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [N_INST-1:0] wave_out,
  input wire logic [N_INST-1:0] offset_hit_out
);
  logic rd_req;
  logic wr_req;
  logic wr_done;
  logic dp_rd;
  logic dp_wr;
  logic [9:0] dp_addr;
  logic en0;
  logic pol0;
  logic [15:0] pr0;
  logic [2:0] quiet;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  assign wr_done = dp_wr && hready;
  // Shadow of what software last wrote; quiet counts cycles since a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd <= 1'h0;
      dp_wr <= 1'h0;
      dp_addr <= 10'h0;
      en0 <= 1'h0;
      pol0 <= 1'h0;
      pr0 <= 16'h0;
      quiet <= 3'h0;
    end else begin
      if (hready) begin
        dp_rd <= rd_req;
        dp_wr <= wr_req;
        dp_addr <= haddr[9:0];
      end
      quiet <= wr_done ? 3'h0 : (quiet == 3'h7) ? quiet : quiet + 3'h1;
      if (wr_done && dp_addr == 10'h000) begin
        en0 <= hwdata[7];
        pol0 <= hwdata[4];
      end
      if (wr_done && dp_addr == 10'h200) begin
        en0 <= hwdata[0];
      end
      if (wr_done && dp_addr == 10'h010) begin
        pr0 <= hwdata[15:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'h0) else $error("response not OKAY");
  write_no_wait_a: assert property (wr_req |=> hreadyout) else $error("write stalled");
  read_one_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  stall_cause_a: assert property ($fell(hreadyout) |-> $past(rd_req))
    else $error("stall without read");
  rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  count_readback_a: assert property (dp_rd && hreadyout && dp_addr == 10'h010
    |-> hrdata[15:0] == pr0) else $error("period count readback wrong");
  unmapped_zero_a: assert property (dp_rd && hreadyout && dp_addr == 10'h03c
    |-> hrdata == 32'h0) else $error("unmapped read not zero");
  idle_polarity_a: assert property (
    quiet == 3'h7 && !en0 |-> wave_out[0] == pol0) else $error("idle level wrong");
  idle_no_hit_a: assert property (
    quiet == 3'h7 && !en0 |-> !offset_hit_out[0]) else $error("hit while disabled");
endmodule : wavegen_assertions

bind wavegen wavegen_assertions #(.N_INST(N_INST)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .wave_out(wave_out),
  .offset_hit_out(offset_hit_out)
);
`default_nettype wire

// File: test/tick_source.sv
// Model of the external counter-clock sources behind ext_tick.
// Assumes hclk and hresetn of the bench; enables at 1/2, 1/4, 1/8 rate.
`timescale 1ns/100ps
`default_nettype none
module tick_source (
  input wire logic hclk,
  input wire logic hresetn,
  output logic [2:0] ext_tick
);
  logic [2:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // Decoded from one counter so each enable is a clean single-cycle pulse
  assign ext_tick = {cnt_r == 3'h7, cnt_r[1:0] == 2'h3, cnt_r[0]};
endmodule : tick_source
`default_nettype wire

// File: test/tb_offset_sync_waveform_generator.sv
// Bench for wavegen: AHB-Lite register tasks, output width and period
// measurement in standard, toggle and center modes, and a slave started by a master offset hit.
`timescale 1ns/100ps
`default_nettype none
module tb_offset_sync_waveform_generator;
  localparam int PH = 2;
  localparam int DC = 5;
  localparam int PR = 9;
  localparam int PS = 2;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] ext_tick;
  logic [1:0] wave_out;
  logic [1:0] offset_hit_out;
  int error_cnt = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  wavegen #(.N_INST(2)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_tick(ext_tick), .wave_out(wave_out),
    .offset_hit_out(offset_hit_out)
  );
  tick_source u_ticks (.hclk(hclk), .hresetn(hresetn), .ext_tick(ext_tick));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic wr_en, input logic [9:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int k;
    k = 0;
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= {22'h0, a};
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'h1 && k < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'h1 && k < 50);
    rd = hrdata;
    if (k >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'h1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'h0, a, 32'h0, x);
    check(x, exp);
  endtask : rdc
  task automatic wait_lvl(input int i, input logic lvl, inout int c);
    while (wave_out[i] !== lvl && c < 600) begin
      @(posedge hclk);
      c++;
    end
  endtask : wait_lvl
  // Skips two periods so a mode change mid-period does not spoil the figures
  task automatic measure(input int i, input int hi, input int per);
    int c;
    int h;
    int p;
    c = 0;
    repeat (2) begin
      wait_lvl(i, 1'h0, c);
      wait_lvl(i, 1'h1, c);
    end
    h = c;
    wait_lvl(i, 1'h0, c);
    p = c;
    wait_lvl(i, 1'h1, c);
    check(32'(p - h), 32'(hi));
    check(32'(c - h), 32'(per));
    if (c >= 600) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : measure
  ////////////////////////////////////////////////////////////
  initial begin
    forever #5 hclk = ~hclk;
  end
  initial begin
    logic [31:0] ctl_t [3] = '{32'h80, 32'h88, 32'h8c};
    int hi_t [3] = '{(DC - PH) * PS, (PR + 1) * PS, 2 * DC * PS};
    int per_t [3] = '{(PR + 1) * PS, 2 * (PR + 1) * PS, 2 * (PR + 1) * PS};
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    check({30'h0, wave_out}, 32'h0);
    rdc(10'h010, 32'h0);
    wr(10'h03c, 32'hffff_ffff);
    rdc(10'h03c, 32'h0);
    wr(10'h000, 32'h10);
    repeat (8) @(posedge hclk);
    check({31'h0, wave_out[0]}, 32'h1);
    rdc(10'h000, 32'h30);
    wr(10'h000, 32'h0);
    // Counter clock is hclk, prescale 2
    wr(10'h004, 32'h4);
    wr(10'h008, 32'(PH));
    wr(10'h00c, 32'(DC));
    wr(10'h010, 32'(PR));
    wr(10'h014, 32'h3);
    wr(10'h018, 32'h80);
    rdc(10'h010, 32'(PR));
    for (int m = 0; m < 3; m++) begin
      wr(10'h000, ctl_t[m]);
      measure(0, hi_t[m], per_t[m]);
    end
    rdc(10'h018, 32'h0);
    wr(10'h000, 32'h84);
    repeat (45) @(posedge hclk);
    check({31'h0, wave_out[0]}, 32'h1);
    repeat (20) @(posedge hclk);
    check({31'h0, wave_out[0]}, 32'h1);
    wr(10'h000, 32'h0);
    repeat (4) @(posedge hclk);
    check({31'h0, wave_out[0]}, 32'h0);
    // Slave on ext_tick[0] at half rate, synchronous start on instance 0
    wr(10'h044, 32'h1);
    wr(10'h048, 32'(PH));
    wr(10'h04c, 32'(DC));
    wr(10'h050, 32'(PR));
    wr(10'h058, 32'h90);
    wr(10'h040, 32'h80);
    repeat (20) @(posedge hclk);
    rdc(10'h05c, 32'h0);
    wr(10'h200, 32'h3);
    rdc(10'h200, 32'h3);
    measure(1, (DC - PH) * 2, (PR + 1) * 2);
    // One-shot slave with a longer period than its master; master then stops
    wr(10'h050, 32'(PR + 2));
    wr(10'h058, 32'ha0);
    wr(10'h000, 32'h0);
    repeat (80) @(posedge hclk);
    rdc(10'h05c, 32'h0);
    tally_and_finish();
  end
endmodule : tb_offset_sync_waveform_generator
`default_nettype wire
